// ---- hdl/radio_cfg_cfg.svh ----
// Offsets, field positions, reset values and counts of the calibration and startup register
`ifndef RADIO_CFG_CFG_SVH
`define RADIO_CFG_CFG_SVH
`define CFG_REG_OFFSET     6'h18
`define CFG_RESET_VALUE    8'h04
`define CFG_USED_MASK      8'h3F
`define FLD_AUTOCAL_HI     5
`define FLD_AUTOCAL_LO     4
`define FLD_PO_HI          3
`define FLD_PO_LO          2
`define FLD_PIN_CTRL       1
`define FLD_OSC_ON         0
`define EXPIRY_COUNT_0     9'h001
`define EXPIRY_COUNT_1     9'h010
`define EXPIRY_COUNT_2     9'h040
`define EXPIRY_COUNT_3     9'h100
`define RIPPLE_MAX         6'h3F
`define IDLE_RETURNS_LAST  2'h3
`endif

// ---- hdl/radio_cfg_pkg.sv ----
// Types of the calibration and startup register block
package radio_cfg_pkg;
    typedef enum logic [1:0] {
        CAL_NEVER     = 2'h0,
        CAL_FROM_IDLE = 2'h1,
        CAL_TO_IDLE   = 2'h2,
        CAL_EVERY_4TH = 2'h3
    } autocal_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_RX    = 4'h2,
        ST_TX    = 4'h4,
        ST_FSTXR = 4'h8
    } radio_state_t;
    typedef enum logic [2:0] {
        PO_WAIT_OSC = 3'h1,
        PO_COUNT    = 3'h2,
        PO_READY    = 3'h4
    } po_state_t;
endpackage

// ---- hdl/radio_sm_calib_startup.sv ----
// Calibration and startup configuration register with its control effects
// Functional notes
// - Two-bit auto-calibration select at bits 5:4, reset zero.
// - Select 0: calibrate only on the manual calibrate strobe.
// - Select 1: calibrate leaving idle for receive, transmit or synth ready.
// - Select 2: calibrate returning from receive or transmit to idle.
// - Select 3: calibrate on every fourth return to idle.
// - Power-on field bits 3:2, reset 1, delays chip ready after oscillator.
// - Field 0..3 needs 1, 16, 64, 256 ripple-counter expiries.
`timescale 1ns/1ps
`include "radio_cfg_cfg.svh"
module radio_sm_calib_startup (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // Register port
    input  wire logic                       reg_wr,
    input  wire logic [5:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    output logic      [7:0]                 reg_rdata,
    // Radio state machine
    input  wire radio_cfg_pkg::radio_state_t radio_state,
    input  wire logic                       manual_calibrate_strobe,
    output logic                            calibrate_start,
    // Oscillator and startup
    input  wire logic                       crystal_oscillator_stable,
    input  wire logic                       sleep_active,
    output logic                            chip_ready_low_active,
    output logic                            keep_oscillator_on_in_sleep,
    output logic                            pin_ctrl_enable
);
    import radio_cfg_pkg::*;

    // Registers and next values
    logic [7:0]   cfg;
    radio_state_t prev_state;
    logic [1:0]   idle_returns;
    logic         osc_meta;
    logic         osc_sync;
    po_state_t    po_state;
    logic [5:0]   ripple;
    logic [8:0]   expiries;
    po_state_t    next_po_state;
    logic [5:0]   next_ripple;
    logic [8:0]   next_count;
    logic         next_chip_ready_low_active;

    // Register port decode
    wire       cfg_hit    = reg_wr && (reg_addr == `CFG_REG_OFFSET);
    wire [7:0] next_cfg   = reg_wdata & `CFG_USED_MASK;
    wire [7:0] next_rdata = (reg_addr == `CFG_REG_OFFSET) ? cfg : 8'h00;

    // Field decode
    wire autocal_t autocal = autocal_t'(cfg[`FLD_AUTOCAL_HI:`FLD_AUTOCAL_LO]);
    wire [1:0]     po_sel  = cfg[`FLD_PO_HI:`FLD_PO_LO];

    // State decode
    wire prev_idle   = (prev_state == ST_IDLE);
    wire prev_active = (prev_state == ST_RX) || (prev_state == ST_TX);
    wire now_idle    = (radio_state == ST_IDLE);
    wire now_active  = (radio_state == ST_RX) || (radio_state == ST_TX) ||
                       (radio_state == ST_FSTXR);
    wire leave_idle  = prev_idle && now_active;
    wire back_idle   = prev_active && now_idle;
    wire fourth      = back_idle && (idle_returns == `IDLE_RETURNS_LAST);
    wire [1:0] next_idle_returns = back_idle ? idle_returns + 2'h1 : idle_returns;

    // Select decode
    wire sel_from = (autocal == CAL_FROM_IDLE);
    wire sel_to   = (autocal == CAL_TO_IDLE);
    wire sel_4th  = (autocal == CAL_EVERY_4TH);
    wire cal_manual = manual_calibrate_strobe;
    wire cal_from   = sel_from && leave_idle;
    wire cal_to     = sel_to && back_idle;
    wire cal_4th    = sel_4th && fourth;
    wire next_cal   = cal_manual || cal_from || cal_to || cal_4th;

    wire [8:0] expiry_target = (po_sel == 2'h0) ? `EXPIRY_COUNT_0 :
                               (po_sel == 2'h1) ? `EXPIRY_COUNT_1 :
                               (po_sel == 2'h2) ? `EXPIRY_COUNT_2 : `EXPIRY_COUNT_3;
    // Ripple counter expiry
    wire       ripple_wrap   = (ripple == `RIPPLE_MAX);
    wire [8:0] next_expiries = expiries + 9'h001;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= `CFG_RESET_VALUE;
        end else if (cfg_hit) begin
            cfg <= next_cfg;
        end
    end

    // Read data register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_returns <= 2'h0;
        end else begin
            idle_returns <= next_idle_returns;
        end
    end

    // Previous radio state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_state <= ST_IDLE;
        end else begin
            prev_state <= radio_state;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calibrate_start <= 1'b0;
        end else begin
            calibrate_start <= next_cal;
        end
    end

    // Oscillator stable synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
        end else begin
            osc_meta <= crystal_oscillator_stable;
            osc_sync <= osc_meta;
        end
    end

    // Startup sequencer
    // startup delay next state
    always_comb begin
        next_po_state              = po_state;
        next_ripple                = ripple;
        next_count                 = expiries;
        next_chip_ready_low_active = chip_ready_low_active;
        case (po_state)
            PO_WAIT_OSC: begin
                next_ripple = 6'h00;
                next_count  = 9'h000;
                if (osc_sync) begin
                    next_po_state = PO_COUNT;
                end
            end
            PO_COUNT: begin
                next_ripple = ripple + 6'h01;
                if (!osc_sync) begin
                    next_po_state = PO_WAIT_OSC;
                end else if (ripple_wrap) begin
                    next_count = next_expiries;
                    if (next_expiries >= expiry_target) begin
                        next_po_state              = PO_READY;
                        next_chip_ready_low_active = 1'b0;
                    end
                end
            end
            PO_READY: begin
                if (!osc_sync) begin
                    next_po_state              = PO_WAIT_OSC;
                    next_chip_ready_low_active = 1'b1;
                end
            end
            default: begin
                next_po_state              = PO_WAIT_OSC;
                next_chip_ready_low_active = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            po_state              <= PO_WAIT_OSC;
            ripple                <= 6'h00;
            expiries              <= 9'h000;
            chip_ready_low_active <= 1'b1;
        end else begin
            po_state              <= next_po_state;
            ripple                <= next_ripple;
            expiries              <= next_count;
            chip_ready_low_active <= next_chip_ready_low_active;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            keep_oscillator_on_in_sleep <= 1'b0;
        end else begin
            keep_oscillator_on_in_sleep <= cfg[`FLD_OSC_ON] && sleep_active;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_ctrl_enable <= 1'b0;
        end else begin
            pin_ctrl_enable <= cfg[`FLD_PIN_CTRL];
        end
    end

endmodule

// ---- dv/radio_sm_calib_startup_properties.sv ----
// Port assertions for the calibration and startup register
`timescale 1ns/1ps
module radio_sm_calib_startup_properties (
    input wire logic clk, rst_b, reg_wr, manual_calibrate_strobe, calibrate_start,
    input wire logic crystal_oscillator_stable, sleep_active, chip_ready_low_active,
    input wire logic keep_oscillator_on_in_sleep, pin_ctrl_enable,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire radio_cfg_pkg::radio_state_t radio_state
);
    logic [8:0] run;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_loss; !crystal_oscillator_stable; endsequence
    // Cycles of unbroken oscillator stability
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) run <= '0;
        else run <= !crystal_oscillator_stable ? 9'h000 : run + {8'h00, run != 9'h1FF};
    end
    chk_rdata_unused: assert property (reg_rdata[7:6] == 2'h0)
        else $error("unused read bits set");
    chk_rdata_unmapped: assert property (reg_addr != 6'h18 |=> reg_rdata == 8'h00)
        else $error("read data at other index");
    chk_manual_cal: assert property (manual_calibrate_strobe |=> calibrate_start)
        else $error("manual strobe without calibration");
    chk_cal_cause: assert property (calibrate_start |->
        $past(manual_calibrate_strobe) || $past(radio_state) != $past(radio_state, 2))
        else $error("calibration without cause");
    chk_pin_change: assert property ($changed(pin_ctrl_enable) |->
        $past(reg_wr, 1) || $past(reg_wr, 2))
        else $error("pin control changed without write");
    chk_osc_sleep: assert property (!sleep_active |=> !keep_oscillator_on_in_sleep)
        else $error("oscillator held outside sleep");
    chk_ready_loss: assert property (s_loss |-> ##[1:4] chip_ready_low_active)
        else $error("ready kept after oscillator loss");
    chk_ready_min: assert property ($fell(chip_ready_low_active) |-> run >= 9'h040)
        else $error("ready too early");
endmodule
bind radio_sm_calib_startup radio_sm_calib_startup_properties u_chk (.*);

// ---- dv/tb_radio_sm_calib_startup.sv ----
// Self-checking bench for the calibration and startup register
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
    $display("unexpected %s: expected %h, seen %h", n, e, s); end end
module tb_radio_sm_calib_startup;
    import radio_cfg_pkg::*;
    typedef struct {logic [1:0] sel; radio_state_t st; logic cal;} row_t;
    logic clk = 0, rst_b = 0, reg_wr = 0, manual_calibrate_strobe = 0;
    logic crystal_oscillator_stable = 0, sleep_active = 0;
    logic [5:0] reg_addr = 6'h18;
    logic [7:0] reg_wdata = 8'h00;
    radio_state_t radio_state = ST_IDLE;
    logic [7:0] reg_rdata;
    logic calibrate_start, chip_ready_low_active, keep_oscillator_on_in_sleep, pin_ctrl_enable;
    int error_cnt = 0, compares = 0, n;
    int expiry[4] = '{64, 1024, 4096, 16384};
    row_t rows[12] = '{'{0, ST_RX, 0}, '{0, ST_IDLE, 0}, '{1, ST_TX, 1}, '{1, ST_IDLE, 0},
        '{1, ST_FSTXR, 1}, '{2, ST_IDLE, 0}, '{2, ST_RX, 0}, '{2, ST_IDLE, 1},
        '{3, ST_TX, 0}, '{3, ST_IDLE, 1}, '{3, ST_RX, 0}, '{3, ST_IDLE, 0}};
    radio_sm_calib_startup DUT (.*);
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk) {reg_wr, reg_addr} = {1'b0, 6'h18};
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial forever #10 clk = ~clk;
    initial begin
        #1000000;
        error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1;
        @(negedge clk);
        `CHK("reset", 11'h021, {reg_rdata, pin_ctrl_enable, keep_oscillator_on_in_sleep, chip_ready_low_active})
        wr(6'h18, 8'hFF);
        sleep_active = 1;
        @(negedge clk);
        `CHK("full write", 10'h0FF, {reg_rdata, pin_ctrl_enable, keep_oscillator_on_in_sleep})
        sleep_active = 0;
        wr(6'h19, 8'h00);
        @(negedge clk);
        `CHK("other index", 8'h3F, reg_rdata)
        wr(6'h18, 8'h00);
        manual_calibrate_strobe = 1;
        @(negedge clk);
        manual_calibrate_strobe = 0;
        `CHK("manual", 1'b1, calibrate_start)
        foreach (rows[i]) begin
            wr(6'h18, {2'h0, rows[i].sel, 4'h0});
            radio_state = rows[i].st;
            @(negedge clk);
            `CHK("calibrate", rows[i].cal, calibrate_start)
        end
        foreach (expiry[p]) begin
            wr(6'h18, {4'h0, p[1:0], 2'h0});
            crystal_oscillator_stable = 1;
            n = 0;
            while (chip_ready_low_active !== 1'b0 && n < 20000) begin
                @(negedge clk);
                n++;
            end
            `CHK("ready delay", 1'b1, n >= expiry[p] && n <= expiry[p] + 8)
            crystal_oscillator_stable = 0;
            repeat (6) @(negedge clk);
        end
        give_verdict;
    end
endmodule
